// ### monitor_code_decoder.v
// Monitor selection code decoder with a Wishbone control and status port
//
// What this block does
// R1: Invalid selection code answers error 0031h.
// R2: Maker codes in the main field return undefined value, no error.
// R3: Invalid index answers error 0032h.
// R4: Legacy 1xxh codes only in main field.
// R5: New codes accepted in main and sub.
// R6: Host clears upper nibble of new main code.
// R7: 01h returns deviation per control mode.
// R8: Deviation index 1 and 2 equal index 0.
// R9: 02h returns encoder resolution.
// R10: 04h returns filtered command position.
// R11: Speeds scaled by speed unit setting.
// R12: 0Ch undefined in torque control.
// R13: 06h returns command torque.
// R14: 07h returns actual or scale position.
// R15: 08h returns unfiltered command position.
// R16: 09h and 0Ah return latched positions.
// R17: 0Dh returns scale position in pulses.
// R18: 11h returns regenerative load ratio.
// R19: 12h returns overload ratio.
// R20: Results are signed 32-bit, 16-bit extended.
// R21: Response echoes selection code and index.
// R22: Answer registered within the request cycle.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "monitor_code_decoder_defs.vh"
module monitor_code_decoder (
   // Clock and reset
   input  wire                  i_clock,
   input  wire                  i_rst_n,
   // Request from the frame parser
   input  wire                  i_req_valid,
   input  wire                  i_req_is_sub,
   input  wire [`CODE_W-1:0]    i_req_code,
   input  wire [`IDX_W-1:0]     i_req_index,
   // Monitored quantities
   input  wire [31:0]           i_deviation_pos,
   input  wire [31:0]           i_deviation_scale,
   input  wire [31:0]           i_encoder_resolution,
   input  wire [31:0]           i_filtered_cmd_position,
   input  wire [31:0]           i_actual_speed_rpm,
   input  wire [31:0]           i_actual_speed_cmd,
   input  wire [15:0]           i_command_torque,
   input  wire [31:0]           i_actual_position,
   input  wire [31:0]           i_unfiltered_cmd_position,
   input  wire [31:0]           i_latched_position_ch_one,
   input  wire [31:0]           i_latched_position_ch_two,
   input  wire [31:0]           i_filtered_cmd_speed_rpm,
   input  wire [31:0]           i_filtered_cmd_speed_cmd,
   input  wire [31:0]           i_scale_position,
   input  wire [15:0]           i_regen_ratio,
   input  wire [15:0]           i_load_ratio,
   // Wishbone slave
   input  wire                  i_wb_cyc,
   input  wire                  i_wb_stb,
   input  wire                  i_wb_we,
   input  wire [3:0]            i_wb_adr,
   input  wire [3:0]            i_wb_sel,
   input  wire [31:0]           i_wb_dat,
   output reg  [31:0]           o_wb_dat,
   output reg                   o_wb_ack,
   // Response
   output reg                   o_rsp_valid,
   output reg                   o_rsp_is_sub,
   output reg                   o_rsp_error,
   output reg  [`ERR_W-1:0]     o_rsp_error_code,
   output reg  [`CODE_W-1:0]    o_rsp_code_echo,
   output reg  [`IDX_W-1:0]     o_rsp_index_echo,
   output reg  [31:0]           o_rsp_monitor
);

   reg  [31:0]        control_r;
   reg  [15:0]        req_count_r;
   reg  [15:0]        err_count_r;

   wire               speed_unit_setting = control_r[`CTRL_UNIT_BIT];
   wire [`MODE_W-1:0] control_mode       = control_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   wire [7:0]         maker_code         = control_r[`CTRL_MAKER_MSB:`CTRL_MAKER_LSB];

   // Sign extension of the short quantities
   function [31:0] extend16;
      input [15:0] v;
      begin
         extend16 = {{16{v[15]}}, v};
      end
   endfunction

   function known_code;
      input [7:0] c;
      begin
         case (c)
            `SEL_DEVIATION, `SEL_RESOLUTION, `SEL_FILT_POS, `SEL_ACT_SPEED, `SEL_TORQUE,
            `SEL_ACT_POS, `SEL_UNFILT_POS, `SEL_LATCH_ONE, `SEL_LATCH_TWO,
            `SEL_FILT_SPEED, `SEL_SCALE_POS, `SEL_REGEN_RATIO, `SEL_LOAD_RATIO:
               known_code = 1'b1;
            default:
               known_code = 1'b0;
         endcase
      end
   endfunction

   // Only a subset of new codes has a legacy twin
   function legacy_twin;
      input [7:0] c;
      begin
         case (c)
            `SEL_DEVIATION, `SEL_RESOLUTION, `SEL_FILT_POS, `SEL_ACT_SPEED, `SEL_TORQUE,
            `SEL_REGEN_RATIO, `SEL_LOAD_RATIO:
               legacy_twin = 1'b1;
            default:
               legacy_twin = 1'b0;
         endcase
      end
   endfunction

   // Both speed monitors share this unit selection
   function [31:0] scaled_speed;
      input        unit;
      input [31:0] per_minute;
      input [31:0] per_cmd;
      begin
         if (unit) begin
            scaled_speed = per_cmd;
         end else begin
            scaled_speed = per_minute;
         end
      end
   endfunction

   // Highest index that each monitor answers to
   function [`IDX_W-1:0] index_limit;
      input [7:0] c;
      begin
         case (c)
            `SEL_DEVIATION: index_limit = `DEV_INDEX_MAX;
            default:        index_limit = `INDEX_NONE;
         endcase
      end
   endfunction

   reg                is_legacy;
   reg                is_new;
   reg  [7:0]         sel;
   reg                code_ok;
   reg                maker;
   reg                index_ok;
   reg  [31:0]        value;
   reg                err_nxt;
   reg  [`ERR_W-1:0]  err_code_nxt;
   reg  [31:0]        monitor_nxt;

   // Code check: a legacy code is refused in the subcommand field
   always @* begin
      is_legacy = (i_req_code & `LEGACY_MASK) == `LEGACY_FLAG;
      is_new    = (i_req_code & `UPPER_NIBBLE_MASK) == 12'h000;
      sel       = i_req_code[7:0];
      maker     = 1'b0;
      code_ok   = 1'b0;
      // Any other upper nibble is neither form and ends as a code error
      if (is_legacy) begin
         code_ok = !i_req_is_sub && legacy_twin(sel);                               // [R4]
      end else if (is_new) begin
         code_ok = known_code(sel);                                                 // [R5]
         // Maker codes are only honoured in the main field
         maker   = !i_req_is_sub && (sel == maker_code) && (maker_code != 8'h00);   // [R2]
      end
   end

   // Deviation takes indexes 0 to 2, every other monitor only 0
   always @* begin
      index_ok = i_req_index <= index_limit(sel);                                   // [R3] [R8]
   end

   // Undefined monitors read as zero so a stale word never leaks out
   always @* begin
      value = `UNDEF_WORD;
      case (sel)
         `SEL_DEVIATION: begin
            if (control_mode == `MODE_POSITION) begin
               value = i_deviation_pos;                                             // [R7]
            end else if (control_mode == `MODE_FULL_CLOSED) begin
               value = i_deviation_scale;                                           // [R7]
            end else begin
               value = `UNDEF_WORD;                                                 // [R7]
            end
         end
         `SEL_RESOLUTION: begin
            value = i_encoder_resolution;                                           // [R9]
         end
         `SEL_FILT_POS: begin
            value = i_filtered_cmd_position;                                        // [R10]
         end
         `SEL_ACT_SPEED: begin
            value = scaled_speed(speed_unit_setting, i_actual_speed_rpm, i_actual_speed_cmd); // [R11]
         end
         `SEL_TORQUE: begin
            value = extend16(i_command_torque);                                     // [R13] [R20]
         end
         `SEL_ACT_POS: begin
            if (control_mode == `MODE_FULL_CLOSED) begin
               value = i_scale_position;                                            // [R14]
            end else begin
               value = i_actual_position;                                           // [R14]
            end
         end
         `SEL_UNFILT_POS: begin
            value = i_unfiltered_cmd_position;                                      // [R15]
         end
         `SEL_LATCH_ONE: begin
            value = i_latched_position_ch_one;                                      // [R16]
         end
         `SEL_LATCH_TWO: begin
            value = i_latched_position_ch_two;                                      // [R16]
         end
         `SEL_FILT_SPEED: begin
            if (control_mode == `MODE_TORQUE) begin
               value = `UNDEF_WORD;                                                 // [R12]
            end else begin                                                          // [R11]
               value = scaled_speed(speed_unit_setting, i_filtered_cmd_speed_rpm,
                                    i_filtered_cmd_speed_cmd);
            end
         end
         `SEL_SCALE_POS: begin
            value = i_scale_position;                                               // [R17]
         end
         `SEL_REGEN_RATIO: begin
            value = extend16(i_regen_ratio);                                        // [R18] [R20]
         end
         `SEL_LOAD_RATIO: begin
            value = extend16(i_load_ratio);                                         // [R19] [R20]
         end
         default: begin
            value = `UNDEF_WORD;
         end
      endcase
   end

   // Priority: maker code, then a bad code, then a bad index
   always @* begin
      err_nxt      = 1'b0;
      err_code_nxt = `ERR_NONE;
      monitor_nxt  = value;
      if (maker) begin
         monitor_nxt = `UNDEF_WORD;                                                 // [R2]
      end else if (!code_ok) begin
         err_nxt      = 1'b1;
         err_code_nxt = `ERR_BAD_CODE;                                              // [R1]
         monitor_nxt  = `UNDEF_WORD;
      end else if (!index_ok) begin
         err_nxt      = 1'b1;
         err_code_nxt = `ERR_BAD_INDEX;                                             // [R3]
         monitor_nxt  = `UNDEF_WORD;
      end
   end

   // One clock of latency keeps the answer well inside the communication cycle
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rsp_valid      <= 1'b0;
         o_rsp_is_sub     <= 1'b0;
         o_rsp_error      <= 1'b0;
         o_rsp_error_code <= `ERR_NONE;
         o_rsp_code_echo  <= {`CODE_W{1'b0}};
         o_rsp_index_echo <= {`IDX_W{1'b0}};
         o_rsp_monitor    <= `UNDEF_WORD;
      end else begin
         o_rsp_valid <= i_req_valid;                                                // [R22]
         if (i_req_valid) begin
            o_rsp_is_sub     <= i_req_is_sub;
            o_rsp_error      <= err_nxt;
            o_rsp_error_code <= err_code_nxt;
            o_rsp_code_echo  <= i_req_code;                                         // [R21]
            o_rsp_index_echo <= i_req_index;                                        // [R21]
            o_rsp_monitor    <= monitor_nxt;                                        // [R22]
         end
      end
   end

   // Counters wrap; they only feed the status word
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_count_r <= 16'h0000;
         err_count_r <= 16'h0000;
      end else if (i_req_valid) begin
         req_count_r <= req_count_r + 16'h0001;
         if (err_nxt) begin
            err_count_r <= err_count_r + 16'h0001;
         end
      end
   end

   // Classic Wishbone: ack one cycle after strobe, dropped the next cycle.
   // A write lands at the edge where the master sees ack, the same edge a read completes.
   wire        wb_req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire        wb_done = i_wb_cyc && i_wb_stb && o_wb_ack;
   wire [31:0] control_nxt;
   reg  [31:0] rd_nxt;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign control_nxt[g*8 +: 8] = i_wb_sel[g] ? i_wb_dat[g*8 +: 8] : control_r[g*8 +: 8];
      end
   endgenerate

   // Unmapped addresses read back zero; a write returns zero data
   always @* begin
      rd_nxt = 32'h00000000;
      if (!i_wb_we) begin
         case (i_wb_adr)
            `ADR_CONTROL: begin
               rd_nxt = control_r;
            end
            `ADR_STATUS: begin
               rd_nxt = {err_count_r, req_count_r};
            end
            default: begin
               rd_nxt = 32'h00000000;
            end
         endcase
      end
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wb_ack  <= 1'b0;
         o_wb_dat  <= 32'h00000000;
         control_r <= `CTRL_RESET;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req) begin
            o_wb_dat <= rd_nxt;
         end
         if (wb_done && i_wb_we && (i_wb_adr == `ADR_CONTROL)) begin
            control_r <= control_nxt;
         end
      end
   end

endmodule

// ### monitor_code_decoder_defs.vh
// Constants for the monitor selection code decoder
`ifndef MONITOR_CODE_DECODER_DEFS_VH
`define MONITOR_CODE_DECODER_DEFS_VH
`define CODE_W            12
`define IDX_W             16
`define ERR_W             16
`define ERR_BAD_CODE      16'h0031
`define ERR_BAD_INDEX     16'h0032
`define ERR_NONE          16'h0000
`define LEGACY_FLAG       12'h100
`define LEGACY_MASK       12'hF00
`define NEW_MASK          12'h0FF
`define UPPER_NIBBLE_MASK 12'hF00
`define SEL_DEVIATION     8'h01
`define SEL_RESOLUTION    8'h02
`define SEL_FILT_POS      8'h04
`define SEL_ACT_SPEED     8'h05
`define SEL_TORQUE        8'h06
`define SEL_ACT_POS       8'h07
`define SEL_UNFILT_POS    8'h08
`define SEL_LATCH_ONE     8'h09
`define SEL_LATCH_TWO     8'h0A
`define SEL_FILT_SPEED    8'h0C
`define SEL_SCALE_POS     8'h0D
`define SEL_REGEN_RATIO   8'h11
`define SEL_LOAD_RATIO    8'h12
`define MODE_W            2
`define MODE_POSITION     2'h0
`define MODE_SPEED        2'h1
`define MODE_TORQUE       2'h2
`define MODE_FULL_CLOSED  2'h3
`define UNDEF_WORD        32'h00000000
`define DEV_INDEX_MAX     16'h0002
`define INDEX_NONE        16'h0000
// Wishbone map: control word at 0x00, status word at 0x04
`define ADR_CONTROL       4'h0
`define ADR_STATUS        4'h4
`define CTRL_UNIT_BIT     0
`define CTRL_MODE_LSB     1
`define CTRL_MODE_MSB     2
`define CTRL_MAKER_LSB    8
`define CTRL_MAKER_MSB    15
`define CTRL_RESET        32'h00000000
`endif

// ### monitor_code_decoder_chk.sv
// Assertion checker for the monitor code decoder
`timescale 1ns/1ps
`include "monitor_code_decoder_defs.vh"
module monitor_code_decoder_chk (
   // Design inputs
   input wire logic        i_clock,
   input wire logic        i_rst_n,
   input wire logic        i_req_valid,
   input wire logic        i_req_is_sub,
   input wire logic [11:0] i_req_code,
   input wire logic [15:0] i_req_index,
   input wire logic [31:0] i_encoder_resolution,
   input wire logic [15:0] i_command_torque,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   // Design outputs
   input wire logic        o_wb_ack,
   input wire logic        o_rsp_valid,
   input wire logic        o_rsp_error,
   input wire logic [15:0] o_rsp_error_code,
   input wire logic [11:0] o_rsp_code_echo,
   input wire logic [15:0] o_rsp_index_echo,
   input wire logic [31:0] o_rsp_monitor
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   rsp_follows_a: assert property (i_req_valid |=> o_rsp_valid) else $error("response missing");
   rsp_pulse_a: assert property (!i_req_valid |=> !o_rsp_valid) else $error("stray response");
   echo_fields_a: assert property (i_req_valid |=> o_rsp_code_echo == $past(i_req_code) &&
      o_rsp_index_echo == $past(i_req_index)) else $error("echo wrong");
   monitor_hold_a: assert property (!i_req_valid |=> $stable(o_rsp_monitor)) else $error("word moved");
   sub_legacy_a: assert property (i_req_valid && i_req_is_sub && i_req_code[11:8] != 4'h0 |=>
      o_rsp_error && o_rsp_error_code == `ERR_BAD_CODE) else $error("legacy in sub accepted");
   error_word_a: assert property (o_rsp_valid && o_rsp_error |->
      o_rsp_monitor == 32'h0 && o_rsp_error_code != `ERR_NONE) else $error("error word wrong");
   torque_ext_a: assert property (i_req_valid && i_req_code == 12'h006 && i_req_index == 16'h0 |=>
      o_rsp_monitor == {{16{$past(i_command_torque[15])}}, $past(i_command_torque)}) else $error("torque wrong");
   resolution_a: assert property (i_req_valid && i_req_code == 12'h002 && i_req_index == 16'h0 |=>
      !o_rsp_error && o_rsp_monitor == $past(i_encoder_resolution)) else $error("resolution wrong");
   index_range_a: assert property (i_req_valid && i_req_code == 12'h001 && i_req_index > 16'h2 |=>
      o_rsp_error_code == `ERR_BAD_INDEX) else $error("index error missing");
   bus_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
   cover property (o_rsp_valid && o_rsp_error);
   cover property (o_rsp_valid && !o_rsp_error);
   cover property (o_wb_ack);
endmodule
bind monitor_code_decoder monitor_code_decoder_chk i_chk (.i_clock, .i_rst_n, .i_req_valid, .i_req_is_sub,
   .i_req_code, .i_req_index, .i_encoder_resolution, .i_command_torque, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
   .o_rsp_valid, .o_rsp_error, .o_rsp_error_code, .o_rsp_code_echo, .o_rsp_index_echo, .o_rsp_monitor);

// ### host_model.sv
// Network host model that issues monitor requests
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic  i_clock,
   // Request toward the decoder
   output logic        o_req_valid,
   output logic        o_req_is_sub,
   output logic [11:0] o_req_code,
   output logic [15:0] o_req_index
);
   initial begin
      o_req_valid = 1'b0;
      o_req_is_sub = 1'b0;
      o_req_code = 12'h000;
      o_req_index = 16'h0000;
   end
   // Callers pick field, code and index; the testbench also sends a legacy code in the sub field and nonzero indexes
   task automatic send(input logic s, input logic [11:0] c, input logic [15:0] x);
      @(posedge i_clock);
      o_req_valid <= 1'b1;
      o_req_is_sub <= s;
      o_req_code <= c;
      o_req_index <= x;
      @(posedge i_clock);
      o_req_valid <= 1'b0;
      // Released code and index flip so a stale value never matches by luck
      o_req_code <= ~c;
      o_req_index <= ~x;
   endtask
endmodule

// ### tb.sv
// Self-checking testbench for the monitor code decoder
`timescale 1ns/1ps
module tb;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
   typedef struct {logic s; logic [11:0] c; logic [15:0] x; logic [15:0] e; logic [31:0] m;} row_t;
   logic        i_clock, i_rst_n, cyc, stb, we;
   logic [3:0]  adr;
   logic [31:0] wdat, rd;
   logic [31:0] mq [0:12];
   logic [15:0] command_torque, rgn, lod;
   wire         rv, rs, ack, ov, os, oe;
   wire  [11:0] rc, oc;
   wire  [15:0] ri, oi, ec;
   wire  [31:0] wd, om;
   int          errors, tests_run;
   row_t        rows[$];
   host_model i_host_model (.i_clock(i_clock), .o_req_valid(rv), .o_req_is_sub(rs), .o_req_code(rc), .o_req_index(ri));
   monitor_code_decoder i_monitor_code_decoder (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req_valid(rv), .i_req_is_sub(rs), .i_req_code(rc), .i_req_index(ri),
      .i_deviation_pos(mq[0]), .i_deviation_scale(mq[1]), .i_encoder_resolution(mq[2]),
      .i_filtered_cmd_position(mq[3]), .i_actual_speed_rpm(mq[4]), .i_actual_speed_cmd(mq[5]),
      .i_command_torque(command_torque), .i_actual_position(mq[6]), .i_unfiltered_cmd_position(mq[7]),
      .i_latched_position_ch_one(mq[8]), .i_latched_position_ch_two(mq[9]), .i_filtered_cmd_speed_rpm(mq[10]),
      .i_filtered_cmd_speed_cmd(mq[11]), .i_scale_position(mq[12]), .i_regen_ratio(rgn), .i_load_ratio(lod),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
      .o_wb_dat(wd), .o_wb_ack(ack), .o_rsp_valid(ov), .o_rsp_is_sub(os), .o_rsp_error(oe),
      .o_rsp_error_code(ec), .o_rsp_code_echo(oc), .o_rsp_index_echo(oi), .o_rsp_monitor(om));
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      // No limit here: a missing ack is left to the watchdog
      do @(posedge i_clock); while (ack !== 1'b1);
      rd = wd;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic add(input logic s, input logic [11:0] c, input logic [15:0] x, e, input logic [31:0] m);
      rows.push_back('{s, c, x, e, m});
   endtask
   task automatic req(input row_t r);
      i_host_model.send(r.s, r.c, r.x);
      @(negedge i_clock);
      `CHK("rsp", {1'b1, r.s, r.e != 16'h0, r.e, r.c, r.x, r.m}, {ov, os, oe, ec, oc, oi, om})
   endtask
   task report_and_stop;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // The run needs some 100 cycles, so 2500 means a hang
   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
   initial begin
      {i_rst_n, cyc, stb, we, adr, wdat} = 0;
      {command_torque, rgn, lod} = {16'h8001, 16'h0123, 16'hFFFE};
      for (int i = 0; i < 13; i++) mq[i] = 32'hC0DE0000 + 32'(i);
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      add(0, 12'h001, 16'h0, 16'h0, mq[0]);
      add(1, 12'h001, 16'h2, 16'h0, mq[0]);
      add(0, 12'h101, 16'h1, 16'h0, mq[0]);
      add(0, 12'h102, 16'h0, 16'h0, mq[2]);
      add(1, 12'h002, 16'h0, 16'h0, mq[2]);
      add(0, 12'h104, 16'h0, 16'h0, mq[3]);
      add(1, 12'h004, 16'h0, 16'h0, mq[3]);
      add(0, 12'h105, 16'h0, 16'h0, mq[4]);
      add(0, 12'h006, 16'h0, 16'h0, {16'hFFFF, command_torque});
      add(0, 12'h007, 16'h0, 16'h0, mq[6]);
      add(1, 12'h008, 16'h0, 16'h0, mq[7]);
      add(0, 12'h009, 16'h0, 16'h0, mq[8]);
      add(1, 12'h00A, 16'h0, 16'h0, mq[9]);
      add(0, 12'h00C, 16'h0, 16'h0, mq[10]);
      add(0, 12'h00D, 16'h0, 16'h0, mq[12]);
      add(0, 12'h111, 16'h0, 16'h0, {16'h0000, rgn});
      add(0, 12'h011, 16'h0, 16'h0, {16'h0000, rgn});
      add(1, 12'h012, 16'h0, 16'h0, {16'hFFFF, lod});
      add(1, 12'h111, 16'h0, 16'h0031, 32'h0);
      add(0, 12'h00E, 16'h0, 16'h0031, 32'h0);
      add(0, 12'h003, 16'h5, 16'h0031, 32'h0);
      add(0, 12'h002, 16'h1, 16'h0032, 32'h0);
      add(1, 12'h001, 16'h3, 16'h0032, 32'h0);
      foreach (rows[i]) req(rows[i]);
      // Full-closed control with command-unit speeds
      wb(1'b1, 4'h0, 32'h7);
      wb(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h7, rd)
      req('{0, 12'h001, 0, 0, mq[1]});
      req('{0, 12'h007, 0, 0, mq[12]});
      req('{0, 12'h105, 0, 0, mq[5]});
      req('{1, 12'h00C, 0, 0, mq[11]});
      wb(1'b1, 4'h0, 32'h4);
      req('{0, 12'h00C, 0, 0, 0});
      req('{0, 12'h001, 0, 0, 0});
      wb(1'b1, 4'h0, 32'h0E00);
      req('{0, 12'h00E, 0, 0, 0});
      wb(1'b1, 4'h8, 32'hFFFF);
      wb(1'b0, 4'h8, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      req('{0, 12'h002, 0, 0, mq[2]});
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      @(negedge i_clock);
      `CHK("reset", 79'h0, {ov, os, oe, ec, oc, oi, om})
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      req('{0, 12'h001, 0, 0, mq[0]});
      report_and_stop();
   end
endmodule
